//--- bench/flash_segment_write_protect_bench.sv
// Self-checking bench of the program memory write/erase gate
`timescale 1ns/1ns
`include "flash_wp_cfg.svh"

module flash_segment_write_protect_bench;
    // Stimulus and observed signals
    logic                    clk;
    logic                    rst_n;
    logic [3:0]              regAddr;
    logic [15:0]             regWrData;
    logic                    regWr;
    logic                    regRd;
    logic [15:0]             regRdData;
    logic                    cfgLoad;
    flash_wp_pkg::cfg_word_t cfgWord;
    flash_wp_pkg::cfg_word_t cfgUpset;
    logic                    reqValid;
    logic [16:0]             reqAddr;
    logic                    reqWrite;
    logic                    reqExternal;
    logic                    ansValid;
    logic                    ansBlocked;
    logic                    devResetReq;
    logic                    irq;
    // Counters
    int                      fails;
    int                      n_checks;

    // Gate under test, default geometry of 256 pages of 512 words
    flash_segment_write_protect dut (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .cfgLoad(cfgLoad), .cfgWord(cfgWord),
        .cfgUpset(cfgUpset), .reqValid(reqValid), .reqAddr(reqAddr), .reqWrite(reqWrite),
        .reqExternal(reqExternal), .ansValid(ansValid), .ansBlocked(ansBlocked),
        .devResetReq(devResetReq), .irq(irq));

    // Sequencer and configuration source
    seq_partner #(.ADDR_W(17)) far (
        .clk(clk), .ansValid(ansValid), .ansBlocked(ansBlocked), .cfgWord(cfgWord),
        .cfgLoad(cfgLoad), .reqValid(reqValid), .reqAddr(reqAddr), .reqWrite(reqWrite),
        .reqExternal(reqExternal));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Word compare
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Single bit compare
    task automatic chkB(input string nm, input logic e, input logic g);
        chk(nm, {15'h0000, e}, {15'h0000, g});
    endtask

    // Register write, one strobe cycle
    task automatic regW(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr     <= 1'b0;
        regWrData <= ~d;
    endtask

    // Register read, data taken in the cycle after the strobe
    task automatic regR(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        #1;
        chk("regRdData", e, regRdData);
    endtask

    // Configuration word from its fields
    function automatic flash_wp_pkg::cfg_word_t cw(input logic gwn, input logic grp, input logic dis,
                                                   input logic bnd, input logic cfn, input logic [7:0] pg);
        return {gwn, grp, dis, bnd, cfn, pg};
    endfunction

    // One request and its answer
    task automatic tryOp(input logic [7:0] pg, input logic [8:0] off, input logic wr, input logic ext,
                         input logic expBlk);
        logic v;
        logic b;
        far.request({pg, off}, wr, ext, v, b);
        chkB("ansValid", 1'b1, v);
        chkB("ansBlocked", expBlk, b);
    endtask

    // Interrupt level after it has had time to follow
    task automatic irqIs(input logic e);
        repeat (2) @(posedge clk);
        #1;
        chkB("irq", e, irq);
    endtask

    // Reset state, read-only and unmapped places, writes before any load
    task automatic tUnloaded();
        regR(`WP_OFS_STATUS, 16'h0004);
        regR(`WP_OFS_CONFIG, 16'h1FFF);
        regW(`WP_OFS_CONFIG, 16'h0000);
        regR(`WP_OFS_CONFIG, 16'h1FFF);
        regR(4'h9, 16'h0000);
        tryOp(8'h00, 9'h000, 1'b1, 1'b0, 1'b1);
    endtask

    // Segment off: global settings alone decide
    task automatic tGlobal();
        far.loadCfg(cw(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00));
        regR(`WP_OFS_CONFIG, 16'h1700);
        tryOp(8'h00, 9'h000, 1'b1, 1'b0, 1'b0);
        tryOp(8'hFF, 9'h1FF, 1'b1, 1'b0, 1'b0);
        far.loadCfg(cw(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00));
        tryOp(8'h40, 9'h010, 1'b1, 1'b0, 1'b1);
        tryOp(8'h40, 9'h010, 1'b0, 1'b0, 1'b0);
        far.loadCfg(cw(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00));
        tryOp(8'hFF, 9'h1FF, 1'b0, 1'b1, 1'b1);
        tryOp(8'h40, 9'h000, 1'b1, 1'b1, 1'b1);
        tryOp(8'h40, 9'h000, 1'b1, 1'b0, 1'b0);
        tryOp(8'h40, 9'h000, 1'b0, 1'b0, 1'b0);
    endtask

    // Segment bounds at the page edges in both modes
    task automatic tSegment();
        far.loadCfg(cw(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'h0A));
        tryOp(8'h09, 9'h1FF, 1'b1, 1'b0, 1'b0);
        tryOp(8'h0A, 9'h000, 1'b1, 1'b0, 1'b1);
        tryOp(8'hFF, 9'h1FF, 1'b1, 1'b0, 1'b1);
        far.loadCfg(cw(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h0A));
        tryOp(8'h00, 9'h000, 1'b1, 1'b0, 1'b1);
        tryOp(8'h0A, 9'h1FF, 1'b1, 1'b0, 1'b1);
        tryOp(8'h0B, 9'h000, 1'b1, 1'b0, 1'b0);
        tryOp(8'hFF, 9'h1FF, 1'b1, 1'b0, 1'b0);
        far.loadCfg(cw(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h0A));
        tryOp(8'hFF, 9'h000, 1'b1, 1'b0, 1'b1);
        tryOp(8'hFE, 9'h1FF, 1'b1, 1'b0, 1'b0);
        tryOp(8'h05, 9'h100, 1'b1, 1'b0, 1'b1);
        far.loadCfg(cw(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h0A));
        tryOp(8'hC8, 9'h000, 1'b1, 1'b0, 1'b1);
        far.loadCfg(cw(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'h0A));
        tryOp(8'hC8, 9'h000, 1'b0, 1'b1, 1'b1);
    endtask

    // Blocked event: sticky status, page capture, mask and clear
    task automatic tIrq();
        regW(`WP_OFS_STATUS, 16'h0003);
        regW(`WP_OFS_MASK, 16'h0002);
        irqIs(1'b0);
        tryOp(8'h07, 9'h044, 1'b1, 1'b0, 1'b1);
        irqIs(1'b1);
        regR(`WP_OFS_LASTBLK, 16'h0007);
        regR(`WP_OFS_STATUS, 16'h000A);
        regW(`WP_OFS_MASK, 16'h0000);
        irqIs(1'b0);
        regW(`WP_OFS_MASK, 16'h0002);
        irqIs(1'b1);
        regW(`WP_OFS_STATUS, 16'h0002);
        irqIs(1'b0);
        regR(`WP_OFS_STATUS, 16'h0008);
        // Blocked event and its clear taken at one edge: the set survives
        fork
            tryOp(8'h07, 9'h044, 1'b1, 1'b0, 1'b1);
            regW(`WP_OFS_STATUS, 16'h0002);
        join
        regR(`WP_OFS_STATUS, 16'h000A);
        regW(`WP_OFS_STATUS, 16'h0002);
    endtask

    // Single cell upset while active: parity flag and reset pulse
    task automatic tParity();
        int n;
        regW(`WP_OFS_MASK, 16'h0001);
        @(posedge clk);
        cfgUpset <= 13'h0010;
        @(posedge clk);
        cfgUpset <= 13'h0000;
        n = 0;
        while (devResetReq !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 8) begin
                fails++;
                $display("MISMATCH devResetReq expected 1 seen %b", devResetReq);
                conclude();
            end
        end
        n = 0;
        while (devResetReq === 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
            #1;
        end
        chk("devResetReq cycles", 16'(`WP_RST_CYCLES), n[15:0]);
        irqIs(1'b1);
        regR(`WP_OFS_STATUS, 16'h0005);
        regR(`WP_OFS_CONFIG, 16'h1FFF);
        tryOp(8'hC8, 9'h000, 1'b1, 1'b0, 1'b1);
        regW(`WP_OFS_STATUS, 16'h0001);
        irqIs(1'b0);
    endtask

    // Main sequence
    initial begin
        fails     = 0;
        n_checks  = 0;
        rst_n     = 1'b0;
        regAddr   = 4'h0;
        regWrData = 16'h0000;
        regWr     = 1'b0;
        regRd     = 1'b0;
        cfgUpset  = 13'h0000;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        tUnloaded();
        tGlobal();
        tSegment();
        tIrq();
        tParity();
        conclude();
    end
endmodule

//--- bench/seq_partner.sv
// Model of the flash write/erase sequencer and the configuration word source
`timescale 1ns/1ns

module seq_partner #(
    parameter int ADDR_W = 17
) (
    // Clock and gate answer
    input  wire logic                    clk,
    input  wire logic                    ansValid,
    input  wire logic                    ansBlocked,
    // Configuration word source
    output flash_wp_pkg::cfg_word_t      cfgWord,
    output logic                         cfgLoad,
    // Sequencer request
    output logic                         reqValid,
    output logic [ADDR_W-1:0]            reqAddr,
    output logic                         reqWrite,
    output logic                         reqExternal
);
    // Idle levels at time zero
    initial begin
        cfgWord     = 13'h0AAA;
        cfgLoad     = 1'b0;
        reqValid    = 1'b0;
        reqAddr     = '0;
        reqWrite    = 1'b0;
        reqExternal = 1'b0;
    end

    // One load pulse; word inverted once released so a stale value cannot pass
    task automatic loadCfg(input flash_wp_pkg::cfg_word_t w);
        @(posedge clk);
        cfgWord <= w;
        cfgLoad <= 1'b1;
        @(posedge clk);
        cfgLoad <= 1'b0;
        cfgWord <= ~w;
    endtask

    // One request pulse, answer sampled in the cycle after the taking edge
    task automatic request(input logic [ADDR_W-1:0] a, input logic wr, input logic ext,
                           output logic vld, output logic blk);
        @(posedge clk);
        reqValid    <= 1'b1;
        reqAddr     <= a;
        reqWrite    <= wr;
        reqExternal <= ext;
        @(posedge clk);
        reqValid    <= 1'b0;
        reqAddr     <= ~a;
        reqWrite    <= ~wr;
        reqExternal <= ~ext;
        #1;
        vld = ansValid;
        blk = ansBlocked;
    endtask
endmodule

//--- hdl/cfg_shadow_check.sv
// Complement shadow of the configuration word and its mismatch detector
`timescale 1ns/1ns
`include "flash_wp_cfg.svh"

module cfg_shadow_check (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Live configuration and its reload
    input  wire flash_wp_pkg::cfg_word_t   value,
    input  wire logic                      load,
    input  wire flash_wp_pkg::cfg_word_t   loadValue,
    // Registered mismatch flag
    output logic                           mismatch
);

    flash_wp_pkg::cfg_word_t shadow_r;  // Holds the complement
    logic [`WP_CFG_W-1:0]    bitBad;    // Per-bit equality means fault

    // Shadow reloads whenever the live word is written
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shadow_r <= ~(`WP_CFG_RST);
        end else if (load) begin
            shadow_r <= ~loadValue;
        end
    end

    // A healthy bit always differs from its shadow
    genvar i;
    generate
        for (i = 0; i < `WP_CFG_W; i++) begin : g_bit
            assign bitBad[i] = value[i] ~^ shadow_r[i];
        end
    endgenerate

    // Continuous compare, registered to keep the path short
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mismatch <= 1'b0;
        end else begin
            mismatch <= |bitBad;
        end
    end

endmodule

//--- hdl/flash_segment_write_protect.sv
// Program memory write/erase gate with segment protection and config shadows
`timescale 1ns/1ns
`include "flash_wp_cfg.svh"

module flash_segment_write_protect #(
    parameter int PAGE_WORDS = 512,
    parameter int NUM_PAGES  = 256,
    parameter int ADDR_W     = $clog2(PAGE_WORDS * NUM_PAGES)
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Register port
    input  wire logic [3:0]              regAddr,
    input  wire logic [15:0]             regWrData,
    input  wire logic                    regWr,
    input  wire logic                    regRd,
    output logic [15:0]                  regRdData,
    // Configuration word source
    input  wire logic                    cfgLoad,
    input  wire flash_wp_pkg::cfg_word_t cfgWord,
    // Storage cell disturbance, xored into live bits
    input  wire flash_wp_pkg::cfg_word_t cfgUpset,
    // Sequencer request
    input  wire logic                    reqValid,
    input  wire logic [ADDR_W-1:0]       reqAddr,
    input  wire logic                    reqWrite,
    input  wire logic                    reqExternal,
    // Sequencer answer
    output logic                         ansValid,
    output logic                         ansBlocked,
    // System
    output logic                         devResetReq,
    output logic                         irq
);

    localparam int PW_BITS = $clog2(PAGE_WORDS);
    localparam int PG_BITS = ADDR_W - PW_BITS;
    localparam logic [7:0] LAST_PAGE = 8'(NUM_PAGES - 1);

    // Page field is 8 bits, so at most 256 pages
    // Checked at elaboration, so a bad geometry never builds any logic
    if (PAGE_WORDS != (1 << PW_BITS) || NUM_PAGES < 2 || NUM_PAGES > 256
        || PG_BITS < 1 || PG_BITS > 8) begin : g_badGeometry
        // Power-of-two pages only, page index must fit the field
        $error("flash_segment_write_protect: unsupported geometry");
    end

    // Page index of an address, zero extended to the field width
    function automatic logic [7:0] pageOf(input logic [ADDR_W-1:0] a);
        logic [7:0] p;
        p = 8'h00;
        p[PG_BITS-1:0] = a[ADDR_W-1:PW_BITS];
        return p;
    endfunction

    // Operating state
    flash_wp_pkg::wp_state_e state_r;
    flash_wp_pkg::wp_state_e state_nxt;

    // Live configuration word
    flash_wp_pkg::cfg_word_t cfg_r;
    flash_wp_pkg::cfg_word_t cfg_nxt;
    logic                    cfgWe;    // Reload of live word and shadow
    logic                    mismatch; // From the shadow checker

    // Reset request counter
    logic [`WP_CNT_W-1:0] rstCnt_r;
    logic [`WP_CNT_W-1:0] rstCnt_nxt;

    // Event status, mask and last blocked page
    logic [`WP_EVT_W-1:0] status_r;
    logic [`WP_EVT_W-1:0] status_nxt;
    logic [`WP_EVT_W-1:0] mask_r;
    logic [`WP_EVT_W-1:0] events;
    logic [7:0]           lastBlk_r;

    // Decoded configuration fields
    wire [7:0] fPage  = cfg_r[`WP_F_PAGE_HI:`WP_F_PAGE_LO];
    wire       fCfgN  = cfg_r[`WP_F_CFGN];
    wire       fBound = cfg_r[`WP_F_BOUND];
    wire       fDis   = cfg_r[`WP_F_DIS];
    wire       fGrp   = cfg_r[`WP_F_GRP];
    wire       fGwrpN = cfg_r[`WP_F_GWRPN];

    // Request page and its relation to the selected page
    wire [7:0] reqPage   = pageOf(reqAddr);
    wire       atOrAbove = reqPage >= fPage;
    wire       atOrBelow = reqPage <= fPage;
    wire       inLast    = reqPage == LAST_PAGE;

    // Segment hit; top mode already reaches the config page
    wire segOn     = !fDis;
    wire hitTop    = segOn && fBound && atOrAbove;
    wire hitBottom = segOn && !fBound && atOrBelow;
    wire hitCfgPg  = segOn && !fBound && !fCfgN && inLast;
    wire segHit    = hitTop || hitBottom || hitCfgPg;

    // Global settings; read protect touches only outside access
    wire extBlock  = reqExternal && fGrp;
    wire wrGlobal  = !fGwrpN;

    // Until a word is loaded every write is refused, the safe side
    wire notReady  = state_r != flash_wp_pkg::ST_ACTIVE;

    // Segment terms are ORed in, so they can only add protection
    wire wrBlock   = wrGlobal || segHit || extBlock || notReady;
    wire blockNow  = reqWrite ? wrBlock : extBlock;

    // Register decode
    wire selStatus  = regAddr == `WP_OFS_STATUS;
    wire selMask    = regAddr == `WP_OFS_MASK;
    wire selConfig  = regAddr == `WP_OFS_CONFIG;
    wire selLastBlk = regAddr == `WP_OFS_LASTBLK;
    wire wrStatus   = regWr && selStatus;
    wire wrMask     = regWr && selMask;

    // Fault entry and exit
    wire faultEnter = mismatch && (state_r != flash_wp_pkg::ST_FAULT);
    wire faultDone  = (state_r == flash_wp_pkg::ST_FAULT) && (rstCnt_r == '0);

    // Read mux; unmapped offsets read zero
    wire [15:0] rdStatus = {11'h000, state_r, status_r};
    wire [15:0] rdMask   = {14'h0000, mask_r};
    wire [15:0] rdConfig = {3'h0, cfg_r};
    wire [15:0] rdLast   = {8'h00, lastBlk_r};
    wire [15:0] rdMux    = selStatus  ? rdStatus :
                           selMask    ? rdMask   :
                           selConfig  ? rdConfig :
                           selLastBlk ? rdLast   : 16'h0000;

    // State sequencing
    always_comb begin
        state_nxt  = state_r;
        rstCnt_nxt = rstCnt_r;
        unique case (state_r)
            flash_wp_pkg::ST_UNLOADED: begin
                // Wait for the first configuration word
                if (faultEnter) begin
                    state_nxt  = flash_wp_pkg::ST_FAULT;
                    rstCnt_nxt = `WP_CNT_W'(`WP_RST_CYCLES - 1);
                end else if (cfgLoad) begin
                    state_nxt = flash_wp_pkg::ST_ACTIVE;
                end
            end
            flash_wp_pkg::ST_ACTIVE: begin
                // Normal gating
                if (faultEnter) begin
                    state_nxt  = flash_wp_pkg::ST_FAULT;
                    rstCnt_nxt = `WP_CNT_W'(`WP_RST_CYCLES - 1);
                end
            end
            flash_wp_pkg::ST_FAULT: begin
                // Hold the reset request, then start over
                if (faultDone) begin
                    state_nxt = flash_wp_pkg::ST_UNLOADED;
                end else begin
                    rstCnt_nxt = rstCnt_r - `WP_CNT_W'(1);
                end
            end
        endcase
    end

    // Live word: fault restores defaults, load wins over upset
    always_comb begin
        cfgWe   = 1'b0;
        cfg_nxt = cfg_r ^ cfgUpset;
        if (state_r == flash_wp_pkg::ST_FAULT) begin
            cfgWe   = 1'b1;
            cfg_nxt = `WP_CFG_RST;
        end else if (cfgLoad && !faultEnter) begin
            cfgWe   = 1'b1;
            cfg_nxt = cfgWord;
        end
    end

    // Events; a set in the clearing cycle survives
    always_comb begin
        events = '0;
        events[`WP_BIT_PARITY]  = faultEnter;
        events[`WP_BIT_BLOCKED] = reqValid && blockNow;
        status_nxt = status_r;
        if (wrStatus) begin
            status_nxt = status_r & ~regWrData[`WP_EVT_W-1:0];
        end
        status_nxt = status_nxt | events;
    end

    // Shadow keeps the complement of every word written to the live copy
    cfg_shadow_check u_shadow (
        .clk       (clk),
        .rst_n     (rst_n),
        .value     (cfg_r),
        .load      (cfgWe),
        .loadValue (cfg_nxt),
        .mismatch  (mismatch)
    );

    // State, counter and live word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r  <= flash_wp_pkg::ST_UNLOADED;
            rstCnt_r <= '0;
            cfg_r    <= `WP_CFG_RST;
        end else begin
            state_r  <= state_nxt;
            rstCnt_r <= rstCnt_nxt;
            cfg_r    <= cfg_nxt;
        end
    end

    // Reset request stands for the whole fault state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            devResetReq <= 1'b0;
        end else begin
            devResetReq <= state_nxt == flash_wp_pkg::ST_FAULT;
        end
    end

    // Answer one cycle after the request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ansValid   <= 1'b0;
            ansBlocked <= 1'b0;
        end else begin
            ansValid   <= reqValid;
            ansBlocked <= reqValid && blockNow;
        end
    end

    // Last blocked page for software diagnosis
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lastBlk_r <= 8'h00;
        end else if (reqValid && blockNow) begin
            lastBlk_r <= reqPage;
        end
    end

    // Status, mask and interrupt
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_r <= '0;
            mask_r   <= '0;
            irq      <= 1'b0;
        end else begin
            status_r <= status_nxt;
            if (wrMask) begin
                mask_r <= regWrData[`WP_EVT_W-1:0];
            end
            irq <= |(status_nxt & (wrMask ? regWrData[`WP_EVT_W-1:0] : mask_r));
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdData <= 16'h0000;
        end else begin
            regRdData <= regRd ? rdMux : 16'h0000;
        end
    end

    // Checks
    wire active = state_r == flash_wp_pkg::ST_ACTIVE;
    wire intWr  = reqValid && reqWrite && !reqExternal && active && !cfgLoad;

    property p_upset_fault;
        @(posedge clk) disable iff (!rst_n)
        (active && !cfgLoad && (cfgUpset != '0)) |-> ##3 (state_r == flash_wp_pkg::ST_FAULT);
    endproperty
    a_upset_fault: assert property (p_upset_fault) else $error("Upset did not fault");

    property p_reset_len;
        @(posedge clk) disable iff (!rst_n)
        $rose(devResetReq) |-> devResetReq [*4] ##1 !devResetReq;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("Reset request length wrong");

    property p_parity_flag;
        @(posedge clk) disable iff (!rst_n)
        $rose(devResetReq) |-> status_r[`WP_BIT_PARITY];
    endproperty
    a_parity_flag: assert property (p_parity_flag) else $error("Parity error not flagged");

    property p_seg_off;
        @(posedge clk) disable iff (!rst_n)
        (intWr && fDis && fGwrpN) |=> (ansValid && !ansBlocked);
    endproperty
    a_seg_off: assert property (p_seg_off) else $error("Disabled segment still blocked");

    property p_top;
        @(posedge clk) disable iff (!rst_n)
        (intWr && !fDis && fBound && atOrAbove) |=> ansBlocked;
    endproperty
    a_top: assert property (p_top) else $error("Top segment write passed");

    property p_bottom;
        @(posedge clk) disable iff (!rst_n)
        (intWr && !fDis && !fBound) |=> (ansBlocked == $past(atOrBelow || (!fCfgN && inLast) || !fGwrpN));
    endproperty
    a_bottom: assert property (p_bottom) else $error("Bottom segment gating wrong");

    property p_cfg_page;
        @(posedge clk) disable iff (!rst_n)
        (intWr && !fDis && !fBound && !fCfgN && inLast) |=> ansBlocked;
    endproperty
    a_cfg_page: assert property (p_cfg_page) else $error("Last page write passed");

    property p_global_wr;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && reqWrite && !fGwrpN) |=> ansBlocked;
    endproperty
    a_global_wr: assert property (p_global_wr) else $error("Global write protect ignored");

    property p_ext_read;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && !reqWrite) |=> (ansBlocked == $past(reqExternal && fGrp));
    endproperty
    a_ext_read: assert property (p_ext_read) else $error("Read gating wrong");

    property p_set_wins;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && blockNow && wrStatus) |=> status_r[`WP_BIT_BLOCKED];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Blocked event lost on clear");

    c_fault:   cover property (@(posedge clk) disable iff (!rst_n) $rose(devResetReq));
    c_blocked: cover property (@(posedge clk) disable iff (!rst_n) ansValid && ansBlocked);
    c_top:     cover property (@(posedge clk) disable iff (!rst_n) intWr && !fDis && fBound && atOrAbove);
    c_irq:     cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));

endmodule

//--- hdl/flash_wp_cfg.svh
// Offsets, field positions, reset values and timing counts of the write-protect block
`ifndef FLASH_WP_CFG_SVH
`define FLASH_WP_CFG_SVH

// Register offsets on the plain register port
`define WP_OFS_STATUS   4'h0
`define WP_OFS_MASK     4'h1
`define WP_OFS_CONFIG   4'h2
`define WP_OFS_LASTBLK  4'h3

// Status and mask bit positions
`define WP_BIT_PARITY   0
`define WP_BIT_BLOCKED  1
`define WP_EVT_W        2
`define WP_ST_LO        2
`define WP_ST_HI        4

// Configuration word field positions
`define WP_CFG_W        13
`define WP_F_PAGE_LO    0
`define WP_F_PAGE_HI    7
`define WP_F_CFGN       8
`define WP_F_BOUND      9
`define WP_F_DIS        10
`define WP_F_GRP        11
`define WP_F_GWRPN      12

// Unprogrammed configuration reads as all ones
`define WP_CFG_RST      13'h1FFF

// Reset request length after a shadow mismatch
`define WP_RST_CYCLES   4
`define WP_CNT_W        3

`endif

//--- hdl/flash_wp_pkg.sv
// Types shared by the write-protect block
`include "flash_wp_cfg.svh"

package flash_wp_pkg;

    // Operating state, one-hot
    typedef enum logic [2:0] {
        ST_UNLOADED = 3'b001,
        ST_ACTIVE   = 3'b010,
        ST_FAULT    = 3'b100
    } wp_state_e;

    // Stored configuration word
    typedef logic [`WP_CFG_W-1:0] cfg_word_t;

endpackage
